// ===== hdl/pdb_top.sv
// pdb_top: output stage of one pwm channel pair with dead time,
// brake override and adc trigger selection, apb register slave.
// assumes raw channel waveforms and counter events come from the
// pwm counter on pclk; brake pins are asynchronous.
//
// What this block does
// R1: complementary legs never high together ahead of the mask stage.
// R2: dead time only while deadtime_enable set.
// R3: select zero: low for count plus one.
// R4: select one: times prescale plus one.
// R5: independent: mask, brake, polarity, enable stages.
// R6: complementary: dead time, then same stages.
// R7: filtered brake pin falling edge is event.
// R8: brake forces outputs to programmed states.
// R9: edge and level brake sources both exist.
// R10: adc trigger on selected event when enabled.
// R11: five counter events selectable for trigger.
// R12: edge brake held until software clears it.
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module pdb_top (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // from the pwm counter, pclk domain
   input wire logic even_raw,
   input wire logic odd_raw,
   input wire logic [pdb_pkg::NUM_EVENTS-1:0] cnt_event,
   // brake pins, asynchronous, active low
   input wire logic [pdb_pkg::NUM_BRK-1:0] brake_input_pin,
   // to the power switches
   output logic even_channel_output,
   output logic odd_channel_output,
   output logic even_output_enable,
   output logic odd_output_enable,
   // to adc and cpu
   output logic adc_trigger,
   output logic irq
);
   import pdb_pkg::*;

   // -----------------------------------------------------------------
   // register file
   // -----------------------------------------------------------------
   logic [31:0] ctrl_q, ctrl_d; // mode, mask, polarity, oe
   logic [31:0] dtc_q, dtc_d; // dead time control
   logic [31:0] brk_q, brk_d; // brake control
   logic [31:0] adc_q, adc_d; // trigger source
   logic [31:0] psc_q, psc_d; // prescale
   logic [STS_W-1:0] sts_q, sts_d; // sticky events
   logic [STS_W-1:0] msk_q, msk_d; // interrupt mask
   logic [31:0] rdat_q, rdat_d; // read data, caught in setup
   logic [STS_W-1:0] ev_set; // events of this cycle
   logic wr_acc; // write access phase
   logic hit; // address is mapped
   logic [NUM_BRK-1:0] pin_q; // filtered pin levels
   logic brake_on; // brake override active

   assign wr_acc = psel & penable & pwrite;
   assign pready = 1'b1; // zero wait states
   assign pslverr = psel & penable & ~hit; // unmapped answers error
   assign prdata = rdat_q;
   assign irq = |(sts_q & msk_q);

   // decode, write and read mux
   always_comb begin
      hit = 1'b1;
      ctrl_d = ctrl_q;
      dtc_d = dtc_q;
      brk_d = brk_q;
      adc_d = adc_q;
      psc_d = psc_q;
      msk_d = msk_q;
      rdat_d = rdat_q;
      case (paddr)
         CTRL_OFF: rdat_d = ctrl_q;
         DTC_OFF: rdat_d = dtc_q;
         BRK_OFF: rdat_d = brk_q;
         ADC_OFF: rdat_d = adc_q;
         PSC_OFF: rdat_d = psc_q;
         STS_OFF: rdat_d = {29'h0, sts_q};
         MSK_OFF: rdat_d = {29'h0, msk_q};
         MON_OFF: rdat_d = {27'h0, brake_on, pin_q};
         default: begin
            hit = 1'b0;
            rdat_d = 32'h0000_0000;
         end
      endcase
      // read data is only refreshed in the setup cycle
      if (!(psel && !penable)) begin
         rdat_d = rdat_q;
      end
      if (wr_acc) begin
         case (paddr)
            CTRL_OFF: ctrl_d = pwdata & CTRL_WMASK;
            DTC_OFF: dtc_d = pwdata & DTC_WMASK;
            BRK_OFF: brk_d = pwdata & BRK_WMASK;
            ADC_OFF: adc_d = pwdata & ADC_WMASK;
            PSC_OFF: psc_d = pwdata & PSC_WMASK;
            MSK_OFF: msk_d = pwdata[STS_W-1:0];
            default: ;
         endcase
      end
      // write one clears, a new event in the same cycle wins
      sts_d = sts_q;
      if (wr_acc && paddr == STS_OFF) begin
         sts_d = sts_q & ~pwdata[STS_W-1:0]; // see R12
      end
      sts_d = sts_d | ev_set;
   end

   // register storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= REG_RST;
         dtc_q <= REG_RST;
         brk_q <= REG_RST;
         adc_q <= REG_RST;
         psc_q <= REG_RST;
         sts_q <= '0;
         msk_q <= '0;
         rdat_q <= REG_RST;
      end else begin
         ctrl_q <= ctrl_d;
         dtc_q <= dtc_d;
         brk_q <= brk_d;
         adc_q <= adc_d;
         psc_q <= psc_d;
         sts_q <= sts_d;
         msk_q <= msk_d;
         rdat_q <= rdat_d;
      end
   end

   // -----------------------------------------------------------------
   // brake pin synchroniser and noise filter
   // -----------------------------------------------------------------
   logic [NUM_BRK-1:0] sy1_q, sy2_q, sy3_q; // three-stage sync
   logic [NUM_BRK-1:0] pin_d;
   logic [NUM_BRK-1:0] fall; // filtered high-to-low per pin
   logic edge_ev; // enabled edge brake event
   logic lvl_on; // enabled pin held low

   // a level is accepted once stages two and three agree
   always_comb begin
      pin_d = pin_q;
      for (int i = 0; i < NUM_BRK; i++) begin
         if (sy2_q[i] == sy3_q[i]) begin
            pin_d[i] = sy3_q[i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sy1_q <= PIN_IDLE;
         sy2_q <= PIN_IDLE;
         sy3_q <= PIN_IDLE;
         pin_q <= PIN_IDLE;
      end else begin
         sy1_q <= brake_input_pin;
         sy2_q <= sy1_q;
         sy3_q <= sy2_q;
         pin_q <= pin_d;
      end
   end

   assign fall = pin_q & ~pin_d; // see R7
   // edge source latches, level source follows the pin
   assign edge_ev = |(fall & brk_q[BRK_EDGE_LSB +: NUM_BRK]); // see R9
   assign lvl_on = |(~pin_q & brk_q[BRK_LVL_LSB +: NUM_BRK]); // see R9
   // edge brake stays until its status bit is cleared
   assign brake_on = sts_q[ST_EDGE] | lvl_on; // see R12

   // -----------------------------------------------------------------
   // dead time insertion
   // -----------------------------------------------------------------
   logic comp; // complementary mode
   logic dt_on; // insertion active
   logic [DT_CNT_W-1:0] dt_cnt;
   logic [PSC_W-1:0] psc;
   logic [24:0] dt_prod; // (count+1)*(prescale+1)
   logic [24:0] dt_prod_m1;
   logic [23:0] dt_len_m1; // low interval minus one cycle
   logic [1:0] src; // waveform entering dead time
   logic [1:0] src_q; // previous, for rising edges
   logic [1:0] rise;
   logic [1:0] dt_o; // waveform after dead time
   logic [23:0] rem_q [2]; // remaining forced-low cycles
   logic [23:0] rem_d [2];

   assign comp = ctrl_q[CT_COMP_BIT];
   assign dt_on = comp & dtc_q[DT_EN_BIT]; // see R2
   assign dt_cnt = dtc_q[DT_CNT_W-1:0];
   assign psc = psc_q[PSC_W-1:0];
   assign dt_prod = ({13'h0, dt_cnt} + 25'd1) * ({13'h0, psc} + 25'd1);
   assign dt_prod_m1 = dt_prod - 25'd1;
   // the prescaled length minus one can never exceed 24 bits
   assign dt_len_m1 = dtc_q[DT_CKSEL_BIT] ? dt_prod_m1[23:0] // see R4
                                          : {12'h0, dt_cnt}; // see R3
   // odd leg is the inverse of even in a complementary pair
   assign src[0] = even_raw;
   assign src[1] = comp ? ~even_raw : odd_raw; // see R6
   assign rise = src & ~src_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_q <= 2'h0;
      end else begin
         src_q <= src;
      end
   end

   genvar k;
   generate
      for (k = 0; k < 2; k++) begin : g_dt
         // a rising leg is held low; the other leg falls at once,
         // so the pair cannot overlap
         always_comb begin
            rem_d[k] = rem_q[k];
            if (!dt_on || !src[k]) begin
               rem_d[k] = 24'h0;
            end else if (rise[k]) begin
               rem_d[k] = dt_len_m1; // see R3
            end else if (rem_q[k] != 24'h0) begin
               rem_d[k] = rem_q[k] - 24'd1;
            end
            // rise cycle counts as the first low cycle
            dt_o[k] = src[k] & ~(dt_on & (rise[k] | (rem_q[k] != 24'h0))); // see R1
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               rem_q[k] <= 24'h0;
            end else begin
               rem_q[k] <= rem_d[k];
            end
         end
      end
   endgenerate

   // -----------------------------------------------------------------
   // output control stages: mask, brake, polarity, enable
   // -----------------------------------------------------------------
   logic [1:0] out_d, out_q; // pin levels
   logic [1:0] oe_d, oe_q; // pin enables
   logic [1:0] brk_st [2]; // brake state code per leg
   assign brk_st[0] = brk_q[BRK_EVEN_LSB +: 2];
   assign brk_st[1] = brk_q[BRK_ODD_LSB +: 2];
   generate
      for (k = 0; k < 2; k++) begin : g_out
         // code 1x forces the leg to bit 0, 0x leaves it alone
         always_comb begin
            out_d[k] = dt_o[k];
            if (ctrl_q[CT_MSKEN_LSB + k]) begin
               out_d[k] = ctrl_q[CT_MSKDAT_LSB + k]; // see R5
            end
            if (brake_on && brk_st[k][1]) begin
               out_d[k] = brk_st[k][0]; // see R8
            end
            out_d[k] = out_d[k] ^ ctrl_q[CT_POL_LSB + k]; // see R5
            oe_d[k] = ctrl_q[CT_OE_LSB + k]; // see R5
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_q <= 2'h0;
         oe_q <= 2'h0;
      end else begin
         out_q <= out_d;
         oe_q <= oe_d;
      end
   end

   assign even_channel_output = out_q[0];
   assign odd_channel_output = out_q[1];
   assign even_output_enable = oe_q[0];
   assign odd_output_enable = oe_q[1];

   // -----------------------------------------------------------------
   // adc trigger selection
   // -----------------------------------------------------------------
   logic [TRG_SEL_W-1:0] trg_sel;
   logic trg_d, trg_q;
   assign trg_sel = adc_q[TRG_SEL_W-1:0];
   // selections five and above pick no event
   always_comb begin
      trg_d = 1'b0;
      if (adc_q[TRG_EN_BIT] && trg_sel < 4'd5) begin // see R11
         trg_d = cnt_event[trg_sel[2:0]]; // see R10
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trg_q <= 1'b0;
      end else begin
         trg_q <= trg_d;
      end
   end
   assign adc_trigger = trg_q;
   assign ev_set = {trg_d, lvl_on, edge_ev};
   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   // a leg whose source has just risen must still be held low
   property p_no_overlap; // see R1
      @(posedge pclk) disable iff (!presetn)
      dt_on |-> !(dt_o[0] && dt_o[1]) && !(rise[0] && dt_o[0]) && !(rise[1] && dt_o[1]);
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("legs overlap"); // see R1
   property p_dt_off; // see R2
      @(posedge pclk) disable iff (!presetn)
      !dt_on |-> (dt_o == src);
   endproperty
   a_dt_off: assert property (p_dt_off) else $error("dead time while off"); // see R2
   property p_dt_len0; // see R3
      @(posedge pclk) disable iff (!presetn)
      dt_on && !dtc_q[DT_CKSEL_BIT] && rise[0] && src[0]
      |=> rem_q[0] == {12'h0, $past(dt_cnt)};
   endproperty
   a_dt_len0: assert property (p_dt_len0) else $error("bad dead time"); // see R3
   property p_dt_len1; // see R4
      @(posedge pclk) disable iff (!presetn)
      dt_on && dtc_q[DT_CKSEL_BIT] && rise[1]
      |=> rem_q[1] + 24'd1 == $past(dt_prod[23:0]);
   endproperty
   a_dt_len1: assert property (p_dt_len1) else $error("bad scaled dead time"); // see R4
   property p_mask; // see R5
      @(posedge pclk) disable iff (!presetn)
      ctrl_q[CT_MSKEN_LSB] && !brake_on
      |=> even_channel_output == $past(ctrl_q[CT_MSKDAT_LSB] ^ ctrl_q[CT_POL_LSB]);
   endproperty
   a_mask: assert property (p_mask) else $error("mask stage wrong"); // see R5
   // a clear may legally follow at once, so only the next cycle is bound
   property p_edge; // see R7
      @(posedge pclk) disable iff (!presetn)
      edge_ev |=> sts_q[ST_EDGE] && brake_on;
   endproperty
   a_edge: assert property (p_edge) else $error("edge brake missed"); // see R7
   property p_brake; // see R8
      @(posedge pclk) disable iff (!presetn)
      brake_on && brk_st[1][1]
      |=> odd_channel_output == $past(brk_st[1][0] ^ ctrl_q[CT_POL_LSB + 1]);
   endproperty
   a_brake: assert property (p_brake) else $error("brake state wrong"); // see R8
   property p_trig; // see R10
      @(posedge pclk) disable iff (!presetn)
      adc_q[TRG_EN_BIT] && trg_sel == 4'd2 && cnt_event[2] |=> adc_trigger;
   endproperty
   a_trig: assert property (p_trig) else $error("trigger missed"); // see R10
   property p_trig_sel; // see R11
      @(posedge pclk) disable iff (!presetn)
      (!adc_q[TRG_EN_BIT] || trg_sel >= 4'd5) |=> !adc_trigger;
   endproperty
   a_trig_sel: assert property (p_trig_sel) else $error("stray trigger"); // see R11
   property p_hold; // see R12
      @(posedge pclk) disable iff (!presetn)
      sts_q[ST_EDGE] && !(wr_acc && paddr == STS_OFF && pwdata[ST_EDGE])
      |=> sts_q[ST_EDGE];
   endproperty
   a_hold: assert property (p_hold) else $error("brake released early"); // see R12
endmodule : pdb_top

// ===== hdl/pdb_pkg.sv
// pdb_pkg: register map, field positions and reset values of the pwm
// output stage (dead time, brake, adc trigger).
// assumes a 32-bit apb slave with byte addresses in paddr.
package pdb_pkg;
   // -----------------------------------------------------------------
   // register offsets (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFF = 8'h00; // mode, mask, polarity, oe
   localparam logic [7:0] DTC_OFF = 8'h04; // deadtime_control_reg
   localparam logic [7:0] BRK_OFF = 8'h08; // brake_control_reg
   localparam logic [7:0] ADC_OFF = 8'h0c; // adc_trigger_source_reg
   localparam logic [7:0] PSC_OFF = 8'h10; // pwm_clock_prescale
   localparam logic [7:0] STS_OFF = 8'h14; // sticky event status, w1c
   localparam logic [7:0] MSK_OFF = 8'h18; // interrupt mask
   localparam logic [7:0] MON_OFF = 8'h1c; // brake monitor, read only
   // -----------------------------------------------------------------
   // writable bits and reset values
   // -----------------------------------------------------------------
   localparam logic [31:0] CTRL_WMASK = 32'h0000_03fd;
   localparam logic [31:0] DTC_WMASK = 32'h0101_0fff;
   localparam logic [31:0] BRK_WMASK = 32'h000f_0f0f;
   localparam logic [31:0] ADC_WMASK = 32'h0000_008f;
   localparam logic [31:0] PSC_WMASK = 32'h0000_0fff;
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int CT_COMP_BIT = 0; // complementary pair mode
   localparam int CT_MSKEN_LSB = 2; // mask enable, 2 bits
   localparam int CT_MSKDAT_LSB = 4; // mask value, 2 bits
   localparam int CT_POL_LSB = 6; // polarity invert, 2 bits
   localparam int CT_OE_LSB = 8; // output enable, 2 bits
   localparam int DT_CNT_W = 12; // deadtime_count width, bits 11:0
   localparam int DT_EN_BIT = 16; // deadtime_enable
   localparam int DT_CKSEL_BIT = 24; // deadtime_clock_select
   localparam int PSC_W = 12; // pwm_clock_prescale width
   localparam int BRK_EDGE_LSB = 0; // edge brake enable per pin
   localparam int BRK_LVL_LSB = 8; // level brake enable per pin
   localparam int BRK_EVEN_LSB = 16; // brake_even_output_state 17:16
   localparam int BRK_ODD_LSB = 18; // brake_odd_output_state 19:18
   localparam int TRG_SEL_W = 4; // adc_trigger_event_select 3:0
   localparam int TRG_EN_BIT = 7; // adc_trigger_enable
   localparam int NUM_EVENTS = 5; // selectable counter events
   localparam int NUM_BRK = 4; // brake pins 0..3
   localparam int ST_EDGE = 0; // edge brake latched
   localparam int ST_LEVEL = 1; // level brake seen
   localparam int ST_TRG = 2; // adc trigger issued
   localparam int STS_W = 3;
   localparam logic [NUM_BRK-1:0] PIN_IDLE = 4'hf; // pins idle high
endpackage : pdb_pkg

// ===== testbench/pdb_far_side.sv
// pdb_far_side: power switch pair and brake pins seen from the board.
// assumes pull-ups on the brake pins and switch drive sampled on pclk.
`timescale 1ns/1ps
module pdb_far_side (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bench request, a zero pulls that pin low
   input wire logic [3:0] brake_cmd,
   output logic [3:0] brake_input_pin,
   // switch drive from the block
   input wire logic even_channel_output,
   input wire logic odd_channel_output,
   input wire logic even_output_enable,
   input wire logic odd_output_enable,
   // sticky shoot-through flag
   output logic overlap_seen
);
   // ----------------------------------------------------------------
   // brake pins
   // ----------------------------------------------------------------
   // open drain with pull-up: released means high, never unknown
   assign brake_input_pin = brake_cmd;
   // ----------------------------------------------------------------
   // switch pair
   // ----------------------------------------------------------------
   // both legs on together would short the supply rail
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overlap_seen <= 1'b0;
      end else if (even_channel_output && odd_channel_output &&
                   even_output_enable && odd_output_enable) begin
         overlap_seen <= 1'b1;
      end
   end
endmodule : pdb_far_side

// ===== testbench/pwm_deadtime_brake_adc_trigger_tb_top.sv
// bench for pdb_top: apb master, raw waveforms, counter events, brakes.
// assumes zero-wait apb slave and the far-side model in pdb_far_side.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
   comparisons++; \
   if ((got) !== (exp)) begin \
      miscompares++; \
      $display("unexpected at %0t: got %h exp %h", $time, got, exp); \
   end \
end
module pwm_deadtime_brake_adc_trigger_tb_top;
   import pdb_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic even_raw, odd_raw, ev_o, od_o, ev_en, od_en, adc_trigger, irq;
   logic [NUM_EVENTS-1:0] cnt_event;
   logic [3:0] brake_cmd, pins;
   logic overlap_seen;
   int miscompares = 0; // mismatches so far
   int comparisons = 0; // checks made
   pdb_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .even_raw, .odd_raw, .cnt_event,
      .brake_input_pin(pins), .even_channel_output(ev_o),
      .odd_channel_output(od_o), .even_output_enable(ev_en),
      .odd_output_enable(od_en), .adc_trigger, .irq);
   pdb_far_side far (.pclk, .presetn, .brake_cmd, .brake_input_pin(pins),
      .even_channel_output(ev_o), .odd_channel_output(od_o),
      .even_output_enable(ev_en), .odd_output_enable(od_en), .overlap_seen);
   // 100 MHz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic give_verdict;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict
   // one apb transfer; waits on pready, never on a fixed count
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         miscompares++;
         give_verdict;
      end
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      `CHK(q, x)
      `CHK(e, xe)
   endtask : rd
   // edges until a leg goes high, bounded
   task automatic to_high(input logic odd_leg, output int k);
      k = 0;
      do begin
         @(posedge pclk);
         #1;
         k++;
      end while ((odd_leg ? od_o : ev_o) !== 1'b1 && k < 80);
   endtask : to_high
   // wait for both legs, a hang ends the run
   task automatic legs(input logic e, input logic o, input int lim);
      int k;
      k = 0;
      do begin
         @(posedge pclk);
         #1;
         k++;
      end while ((ev_o !== e || od_o !== o) && k < lim);
      `CHK({ev_o, od_o}, {e, o})
      if (ev_o !== e || od_o !== o) begin
         give_verdict;
      end
   endtask : legs
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // reset values, masks, read-only and unmapped places
   task automatic t_regs;
      for (int a = 0; a < 8; a++) begin
         rd(8'(a * 4), (a == 7) ? 32'h0000_000f : REG_RST, 1'b0);
      end
      rd(8'h20, 32'h0, 1'b1);
      wr(MON_OFF, 32'h0);
      rd(MON_OFF, 32'h0000_000f, 1'b0);
      wr(DTC_OFF, 32'hffff_ffff);
      rd(DTC_OFF, 32'h0101_0fff, 1'b0);
   endtask : t_regs
   // mask, polarity and enable stages in independent mode
   task automatic t_indep;
      @(posedge pclk);
      even_raw <= 1'b1;
      wr(CTRL_OFF, 32'h0000_0300);
      legs(1'b1, 1'b0, 4);
      `CHK({ev_en, od_en}, 2'b11)
      wr(CTRL_OFF, 32'h0000_03c0);
      legs(1'b0, 1'b1, 4);
      wr(CTRL_OFF, 32'h0000_032c);
      legs(1'b0, 1'b1, 4);
      @(posedge pclk);
      even_raw <= 1'b0;
   endtask : t_indep
   // dead time on both rising legs; falling legs are immediate
   task automatic t_dead(input int cnt, input logic sel, input logic en, input int psc);
      int k, x;
      x = en ? (cnt + 1) * (sel ? psc + 1 : 1) + 1 : 1;
      wr(PSC_OFF, 32'(psc));
      wr(DTC_OFF, (32'(sel) << 24) | (32'(en) << 16) | 32'(cnt));
      wr(CTRL_OFF, 32'h0000_0301);
      repeat (20) @(posedge pclk);
      even_raw <= 1'b1;
      to_high(1'b0, k);
      `CHK(k, x)
      `CHK(od_o, 1'b0)
      @(posedge pclk);
      even_raw <= 1'b0;
      to_high(1'b1, k);
      `CHK(k, x)
   endtask : t_dead
   // edge brake holds until cleared, level brake follows the pin
   task automatic t_brake;
      wr(CTRL_OFF, 32'h0000_0300);
      @(posedge pclk);
      odd_raw <= 1'b1;
      wr(MSK_OFF, 32'h0000_0001);
      wr(BRK_OFF, 32'h000b_0001);
      brake_cmd[0] <= 1'b0;
      legs(1'b1, 1'b0, 12);
      `CHK(irq, 1'b1)
      rd(STS_OFF, 32'h0000_0001, 1'b0);
      @(posedge pclk);
      brake_cmd[0] <= 1'b1;
      repeat (10) @(posedge pclk);
      #1;
      `CHK({ev_o, od_o}, 2'b10)
      wr(STS_OFF, 32'h0000_0001);
      legs(1'b0, 1'b1, 8);
      `CHK(irq, 1'b0)
      wr(MSK_OFF, 32'h0);
      // even code 01 leaves the leg alone, odd code 10 forces it low
      wr(BRK_OFF, 32'h0009_0200);
      brake_cmd[1] <= 1'b0;
      legs(1'b0, 1'b0, 12);
      `CHK(irq, 1'b0)
      @(posedge pclk);
      brake_cmd[1] <= 1'b1;
      legs(1'b0, 1'b1, 12);
      rd(STS_OFF, 32'h0000_0002, 1'b0);
      wr(MSK_OFF, 32'h0000_0002);
      // mask and status settle after the write edge
      #1;
      `CHK(irq, 1'b1)
      wr(STS_OFF, 32'h0000_0002);
      #1;
      `CHK(irq, 1'b0)
   endtask : t_brake
   // pulse events and count trigger pulses
   task automatic pulse(input logic [NUM_EVENTS-1:0] ev, input int x);
      int n;
      @(posedge pclk);
      cnt_event <= ev;
      @(posedge pclk);
      cnt_event <= '0;
      n = 0;
      repeat (4) begin
         #1;
         if (adc_trigger !== 1'b0) n++;
         @(posedge pclk);
      end
      `CHK(n, x)
   endtask : pulse
   task automatic t_adc;
      for (int s = 0; s < NUM_EVENTS; s++) begin
         wr(ADC_OFF, 32'h80 | 32'(s));
         pulse(5'(1 << s), 1);
         pulse(5'(1 << ((s + 1) % NUM_EVENTS)), 0);
      end
      wr(ADC_OFF, 32'h0000_0085);
      pulse(5'h1f, 0);
      wr(ADC_OFF, 32'h0000_0000);
      pulse(5'h01, 0);
      rd(STS_OFF, 32'h0000_0004, 1'b0);
   endtask : t_adc
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, even_raw, odd_raw} = '0;
      paddr = '0;
      pwdata = '0;
      cnt_event = '0;
      brake_cmd = 4'hf;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_indep();
      t_dead(2, 1'b0, 1'b1, 0);
      t_dead(0, 1'b0, 1'b1, 0);
      t_dead(1, 1'b1, 1'b1, 2);
      t_dead(5, 1'b0, 1'b0, 0);
      t_brake();
      t_adc();
      `CHK(overlap_seen, 1'b0)
      give_verdict;
   end
endmodule : pwm_deadtime_brake_adc_trigger_tb_top
